// >>> design/irq_cfg.svh
// Purpose: Constants for the two level interrupt handler.
// Assumes: Special function addresses are byte addresses on an 8-bit bus.
// Notes: Included by the package and the handler design file.
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
`define IRQ_ADDR_EN_MAIN 8'hA8
`define IRQ_ADDR_PRI_MAIN 8'hB8
`define IRQ_ADDR_EN_EXT_A 8'hE6
`define IRQ_ADDR_EN_EXT_B 8'hE7
`define IRQ_ADDR_PRI_EXT_A 8'hF6
`define IRQ_ADDR_PRI_EXT_B 8'hF7
`define IRQ_PAGE_ZERO 8'h00
`define IRQ_RST_BYTE 8'h00
`define IRQ_RST_PRI7 7'h00
`define IRQ_GLOBAL_BIT 7
`define IRQ_MAX_SRC 23
`define IRQ_VEC_BASE 16'h0003
`define IRQ_VEC_STRIDE 16'h0008
`define IRQ_HWCLR_MASK 23'h00000F
`endif

// >>> design/irq_pkg.sv
// Purpose: Types shared by the interrupt handler files.
// Assumes: At most 23 sources, matching the enable register bits.
// Notes: Numbers live in irq_cfg.svh.
`include "irq_cfg.svh"
package irq_pkg;
	typedef logic [4:0] src_idx_t;
	typedef logic [`IRQ_MAX_SRC-1:0] src_vec_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] page;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} sfr_req_t;
	typedef struct packed {
		logic instr_done;
		logic return_from_interrupt;
	} core_evt_t;
	typedef struct packed {
		logic [7:0] en_main;
		logic [6:0] pri_main;
		logic [7:0] en_ext_a;
		logic [7:0] en_ext_b;
		logic [7:0] pri_ext_a;
		logic [7:0] pri_ext_b;
		logic win_valid;
		logic win_hi;
		src_idx_t win_idx;
		logic act_hi;
		logic act_lo;
		logic hold;
		logic call;
		logic call_hi;
		src_idx_t call_idx;
		logic [15:0] vector;
		logic [7:0] rdata;
	} ctl_state_t;
endpackage

// >>> design/irq_flag_bank.sv
// Purpose: Pending flags of all sources, combined per source.
// Assumes: Set, clear and hardware clear inputs are on the core clock.
// Notes: A set in the same cycle as a clear leaves the flag set.
`timescale 1ns/100ps
`default_nettype none
module irq_flag_bank #(
	parameter int NUM_SRC = 19,
	parameter int FLAGS = 4
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic [NUM_SRC*FLAGS-1:0] set_in,
	input wire logic [NUM_SRC*FLAGS-1:0] clr_in,
	input wire logic [NUM_SRC-1:0] hwclr_in,
	output logic [NUM_SRC*FLAGS-1:0] pend_out,
	output logic [NUM_SRC-1:0] req_out
);
	typedef struct packed {
		logic [NUM_SRC*FLAGS-1:0] pend;
	} flag_state_t;
	flag_state_t st_ff;
	flag_state_t nxt_st;
	logic [NUM_SRC*FLAGS-1:0] hw_wide;

	initial begin
		if (NUM_SRC < 1 || FLAGS < 1) begin
			$error("irq_flag_bank needs at least one source and one flag");
		end
	end

	always_comb begin
		for (int s = 0; s < NUM_SRC; s++) begin
			hw_wide[s*FLAGS +: FLAGS] = {FLAGS{hwclr_in[s]}};
			req_out[s] = |st_ff.pend[s*FLAGS +: FLAGS];
		end
		nxt_st = st_ff;
		nxt_st.pend = (st_ff.pend & ~(clr_in | hw_wide)) | set_in;
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pend_out = st_ff.pend;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	property p_flag_set;
		(set_in != '0) |=> ((pend_out & $past(set_in)) == $past(set_in));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set by event");

	property p_flag_clr;
		(clr_in != '0) |=> ((pend_out & $past(clr_in) & ~$past(set_in)) == '0);
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared by software");

	property p_flag_hwclr;
		(hwclr_in != '0) |=> ((req_out & $past(hwclr_in)) == '0) || ($past(set_in) != '0);
	endproperty
	a_flag_hwclr: assert property (p_flag_hwclr) else $error("flag not cleared on vector");
endmodule // irq_flag_bank
`default_nettype wire

// >>> design/two_level_interrupt_handler.sv
// Purpose: Two level interrupt handler with enable and priority registers.
// Assumes: The core pulses instr_done at each instruction end and return_from_interrupt when a return completes.
// Notes: A call pulse tells the core to make a long call to the given vector.
`timescale 1ns/100ps
`default_nettype none
`include "irq_cfg.svh"
module two_level_interrupt_handler
	import irq_pkg::*;
#(
	parameter int NUM_SRC = 19,
	parameter int FLAGS = 4
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire sfr_req_t sfr_req_in,
	output logic [7:0] sfr_rdata_out,
	input wire core_evt_t core_evt_in,
	input wire logic [NUM_SRC*FLAGS-1:0] flag_set_in,
	input wire logic [NUM_SRC*FLAGS-1:0] flag_clr_in,
	output logic [NUM_SRC*FLAGS-1:0] flag_pend_out,
	output logic irq_req_out,
	output logic call_out,
	output logic call_hi_out,
	output src_idx_t call_idx_out,
	output logic [15:0] vector_out
);
	ctl_state_t st_ff;
	ctl_state_t nxt_st;
	logic [NUM_SRC-1:0] req;
	logic [NUM_SRC-1:0] hwclr;
	src_vec_t req_w;
	src_vec_t en_vec;
	src_vec_t pri_vec;
	src_vec_t gated;
	src_vec_t elig_hi;
	src_vec_t elig_lo;
	src_vec_t hw_hit;
	logic still;
	logic launch;
	logic page0;

	initial begin
		if (NUM_SRC < 1 || NUM_SRC > `IRQ_MAX_SRC || FLAGS < 1) begin
			$error("two_level_interrupt_handler source count out of range");
		end
	end

	function automatic src_idx_t first_set(input src_vec_t v);
		src_idx_t r;
		r = '0;
		for (int i = `IRQ_MAX_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = src_idx_t'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] vec_of(input src_idx_t idx);
		return `IRQ_VEC_BASE + `IRQ_VEC_STRIDE * {11'h000, idx};
	endfunction

	irq_flag_bank #(
		.NUM_SRC(NUM_SRC),
		.FLAGS(FLAGS)
	) u_flags (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.set_in(flag_set_in),
		.clr_in(flag_clr_in),
		.hwclr_in(hwclr),
		.pend_out(flag_pend_out),
		.req_out(req)
	);

	always_comb begin
		nxt_st = st_ff;
		page0 = (sfr_req_in.page == `IRQ_PAGE_ZERO);
		req_w = `IRQ_MAX_SRC'(req);
		en_vec = {st_ff.en_ext_b, st_ff.en_ext_a, st_ff.en_main[6:0]};
		pri_vec = {st_ff.pri_ext_b, st_ff.pri_ext_a, st_ff.pri_main};
		gated = req_w & en_vec & {`IRQ_MAX_SRC{st_ff.en_main[`IRQ_GLOBAL_BIT]}};
		elig_hi = gated & pri_vec & {`IRQ_MAX_SRC{!st_ff.act_hi}};
		elig_lo = gated & ~pri_vec & {`IRQ_MAX_SRC{!st_ff.act_hi && !st_ff.act_lo}};
		nxt_st.win_valid = (elig_hi != '0) || (elig_lo != '0);
		nxt_st.win_hi = (elig_hi != '0);
		nxt_st.win_idx = first_set((elig_hi != '0) ? elig_hi : elig_lo);
		still = st_ff.win_hi ? elig_hi[st_ff.win_idx] : (elig_lo[st_ff.win_idx] && elig_hi == '0);
		launch = core_evt_in.instr_done && !core_evt_in.return_from_interrupt && st_ff.win_valid && still
			&& !st_ff.hold;
		hw_hit = launch ? ((`IRQ_MAX_SRC'(1) << st_ff.win_idx) & `IRQ_HWCLR_MASK) : '0;
		hwclr = hw_hit[NUM_SRC-1:0];
		nxt_st.call = launch;
		if (launch) begin
			nxt_st.call_hi = st_ff.win_hi;
			nxt_st.call_idx = st_ff.win_idx;
			nxt_st.vector = vec_of(st_ff.win_idx);
			if (st_ff.win_hi) begin
				nxt_st.act_hi = 1'b1;
			end else begin
				nxt_st.act_lo = 1'b1;
			end
		end
		if (core_evt_in.return_from_interrupt) begin
			nxt_st.hold = 1'b1;
			if (st_ff.act_hi) begin
				nxt_st.act_hi = 1'b0;
			end else begin
				nxt_st.act_lo = 1'b0;
			end
		end else if (core_evt_in.instr_done) begin
			nxt_st.hold = 1'b0;
		end
		if (sfr_req_in.rd) begin
			nxt_st.rdata = 8'h00;
		end
		case (sfr_req_in.addr)
			`IRQ_ADDR_EN_MAIN: begin
				if (sfr_req_in.rd) begin
					nxt_st.rdata = st_ff.en_main;
				end
				if (sfr_req_in.wr) begin
					nxt_st.en_main = sfr_req_in.wdata;
				end
			end
			`IRQ_ADDR_PRI_MAIN: begin
				if (page0 && sfr_req_in.rd) begin
					nxt_st.rdata = {1'b0, st_ff.pri_main};
				end
				if (page0 && sfr_req_in.wr) begin
					nxt_st.pri_main = sfr_req_in.wdata[6:0];
				end
			end
			`IRQ_ADDR_EN_EXT_A: begin
				if (sfr_req_in.rd) begin
					nxt_st.rdata = st_ff.en_ext_a;
				end
				if (sfr_req_in.wr) begin
					nxt_st.en_ext_a = sfr_req_in.wdata;
				end
			end
			`IRQ_ADDR_EN_EXT_B: begin
				if (sfr_req_in.rd) begin
					nxt_st.rdata = st_ff.en_ext_b;
				end
				if (sfr_req_in.wr) begin
					nxt_st.en_ext_b = sfr_req_in.wdata;
				end
			end
			`IRQ_ADDR_PRI_EXT_A: begin
				if (page0 && sfr_req_in.rd) begin
					nxt_st.rdata = st_ff.pri_ext_a;
				end
				if (page0 && sfr_req_in.wr) begin
					nxt_st.pri_ext_a = sfr_req_in.wdata;
				end
			end
			`IRQ_ADDR_PRI_EXT_B: begin
				if (page0 && sfr_req_in.rd) begin
					nxt_st.rdata = st_ff.pri_ext_b;
				end
				if (page0 && sfr_req_in.wr) begin
					nxt_st.pri_ext_b = sfr_req_in.wdata;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_ff <= '0;
			st_ff.pri_main <= `IRQ_RST_PRI7;
			st_ff.en_main <= `IRQ_RST_BYTE;
			st_ff.pri_ext_a <= `IRQ_RST_BYTE;
			st_ff.pri_ext_b <= `IRQ_RST_BYTE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sfr_rdata_out = st_ff.rdata;
	assign irq_req_out = st_ff.win_valid;
	assign call_out = st_ff.call;
	assign call_hi_out = st_ff.call_hi;
	assign call_idx_out = st_ff.call_idx;
	assign vector_out = st_ff.vector;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	property p_call_enabled;
		call_out |-> $past(st_ff.en_main[`IRQ_GLOBAL_BIT]) && $past(en_vec[st_ff.win_idx]);
	endproperty
	a_call_enabled: assert property (p_call_enabled) else $error("call for disabled source");

	property p_call_vector;
		call_out |-> vector_out == `IRQ_VEC_BASE + `IRQ_VEC_STRIDE * {11'h000, call_idx_out};
	endproperty
	a_call_vector: assert property (p_call_vector) else $error("wrong vector address");

	property p_call_after_instr;
		call_out |-> $past(core_evt_in.instr_done);
	endproperty
	a_call_after_instr: assert property (p_call_after_instr) else $error("call before instruction end");

	property p_hi_not_preempted;
		$past(st_ff.act_hi) |-> !call_out;
	endproperty
	a_hi_not_preempted: assert property (p_hi_not_preempted) else $error("high routine preempted");

	sequence s_return_from_interrupt;
		core_evt_in.return_from_interrupt;
	endsequence
	property p_return_from_interrupt_gap;
		s_return_from_interrupt |=> !call_out [*2];
	endproperty
	a_return_from_interrupt_gap: assert property (p_return_from_interrupt_gap) else $error("re-entry without one instruction");

	property p_level_order;
		$past(elig_hi != '0) |-> st_ff.win_valid && st_ff.win_hi;
	endproperty
	a_level_order: assert property (p_level_order) else $error("high level not chosen first");

	property p_global_off;
		!st_ff.en_main[`IRQ_GLOBAL_BIT] |=> !call_out;
	endproperty
	a_global_off: assert property (p_global_off) else $error("call while globally disabled");
endmodule // two_level_interrupt_handler
`default_nettype wire

// >>> tb/core_model.sv
// Purpose: Behavioural core giving instruction ends and returns.
// Assumes: One instruction ends each cycle, or each fourth cycle when slow.
// Notes: A return cycle ends no instruction.
`timescale 1ns/100ps
`default_nettype none
module core_model
	import irq_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic return_from_interrupt_go_in,
	input wire logic slow_in,
	output var core_evt_t evt_out
);
	logic [1:0] cnt;
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt <= 2'h0;
			evt_out <= '0;
		end else begin
			cnt <= cnt + 2'h1;
			evt_out.return_from_interrupt <= #1 return_from_interrupt_go_in;
			evt_out.instr_done <= #1 !return_from_interrupt_go_in && (!slow_in || cnt == 2'h0);
		end
	end
endmodule // core_model
`default_nettype wire

// >>> tb/two_level_interrupt_handler_tb_top.sv
// Purpose: Self-checking bench for the interrupt handler.
// Assumes: Default of 19 sources with 4 flags each.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
module two_level_interrupt_handler_tb_top
	import irq_pkg::*;
;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	sfr_req_t req = '0;
	core_evt_t evt;
	logic [75:0] fset = '0;
	logic [75:0] fclr = '0;
	logic [75:0] pend;
	logic [7:0] rdata;
	logic irq, call, call_hi, return_from_interrupt_go = 1'b0, slow = 1'b0;
	src_idx_t idx;
	logic [15:0] vec;
	int n_fail = 0;
	int tests_run = 0;
	logic [7:0] am [6] = '{8'hA8, 8'hB8, 8'hE6, 8'hE7, 8'hF6, 8'hF7};

	always #2.5 core_clk_in = ~core_clk_in;

	two_level_interrupt_handler i_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.sfr_req_in(req), .sfr_rdata_out(rdata), .core_evt_in(evt), .flag_set_in(fset),
		.flag_clr_in(fclr), .flag_pend_out(pend), .irq_req_out(irq), .call_out(call),
		.call_hi_out(call_hi), .call_idx_out(idx), .vector_out(vec));
	core_model i_core (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.return_from_interrupt_go_in(return_from_interrupt_go), .slow_in(slow), .evt_out(evt));

	task stop_test();
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick();
		@(posedge core_clk_in);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
		req = '{addr: a, page: p, wr: 1'b1, rd: 1'b0, wdata: d};
		tick();
		req.wr = 1'b0;
		tick();
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] p, input logic [7:0] exp);
		req = '{addr: a, page: p, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		tick();
		req.rd = 1'b0;
		tick();
		check({8'h00, rdata}, {8'h00, exp});
	endtask
	task pulse(input logic [75:0] s, input logic [75:0] c);
		fset = s;
		fclr = c;
		tick();
		fset = '0;
		fclr = '0;
		tick();
	endtask
	task return_from_interrupt();
		return_from_interrupt_go = 1'b1;
		tick();
		return_from_interrupt_go = 1'b0;
		tick();
	endtask
	task wcall(input src_idx_t i, input logic h);
		int k;
		k = 0;
		while (call !== 1'b1 && k < 40) begin
			tick();
			k++;
		end
		check({9'h000, call, call_hi, i}, {9'h000, 1'b1, h, idx});
		check(vec, 16'h0003 + {8'h00, i, 3'h0});
		tick();
	endtask
	task nocall(input int n);
		repeat (n) begin
			tick();
			check({15'h0000, call}, 16'h0000);
		end
	endtask
	function automatic logic [75:0] fb(input int s, input int f);
		return 76'h1 << (s * 4 + f);
	endfunction

	initial begin
		#50000;
		n_fail++;
		stop_test();
	end

	initial begin
		repeat (2) @(posedge core_clk_in);
		#1 rst_b_in = 1'b1;
		tick();
		for (int j = 0; j < 6; j++) rdc(am[j], 8'h00, 8'h00);
		wr(8'hE6, 8'h05, 8'hA5);
		rdc(8'hE6, 8'h05, 8'hA5);
		wr(8'hF6, 8'h05, 8'h33);
		rdc(8'hF6, 8'h00, 8'h00);
		wr(8'hF7, 8'h00, 8'h33);
		rdc(8'hF7, 8'h00, 8'h33);
		rdc(8'hF7, 8'h05, 8'h00);
		wr(8'hB8, 8'h00, 8'hFF);
		rdc(8'hB8, 8'h00, 8'h7F);
		wr(8'hA9, 8'h00, 8'h55);
		rdc(8'hA9, 8'h00, 8'h00);
		wr(8'hE6, 8'h00, 8'h00);
		wr(8'hF7, 8'h00, 8'h00);
		wr(8'hB8, 8'h00, 8'h00);
		pulse(fb(1, 2), '0);
		check({15'h0000, pend[6]}, 16'h0001);
		check({15'h0000, irq}, 16'h0000);
		wr(8'hA8, 8'h00, 8'h02);
		nocall(3);
		wr(8'hA8, 8'h07, 8'h82);
		check({15'h0000, irq}, 16'h0001);
		wcall(5'h01, 1'b0);
		check({15'h0000, pend[6]}, 16'h0000);
		return_from_interrupt();
		slow = 1'b1;
		pulse(fb(5, 0), '0);
		wr(8'hA8, 8'h00, 8'hA0);
		wcall(5'h05, 1'b0);
		check({15'h0000, pend[20]}, 16'h0001);
		return_from_interrupt();
		wcall(5'h05, 1'b0);
		pulse('0, fb(5, 0));
		return_from_interrupt();
		nocall(4);
		slow = 1'b0;
		wr(8'hB8, 8'h00, 8'h40);
		wr(8'hA8, 8'h00, 8'hD4);
		pulse(fb(2, 0) | fb(4, 1) | fb(6, 3), '0);
		wcall(5'h06, 1'b1);
		pulse('0, fb(6, 3));
		return_from_interrupt();
		wcall(5'h02, 1'b0);
		nocall(6);
		pulse(fb(6, 0), '0);
		wcall(5'h06, 1'b1);
		pulse('0, fb(6, 0));
		return_from_interrupt();
		nocall(4);
		return_from_interrupt();
		wcall(5'h04, 1'b0);
		pulse('0, fb(4, 1));
		return_from_interrupt();
		tick();
		check({15'h0000, irq}, 16'h0000);
		stop_test();
	end
endmodule // two_level_interrupt_handler_tb_top
`default_nettype wire
